// ### snd_map.svh
`ifndef SND_MAP_SVH
`define SND_MAP_SVH
`define SND_OP_WREN   8'h06
`define SND_OP_WRDI   8'h04
`define SND_OP_GETF   8'h0f
`define SND_OP_PGRD   8'h13
`define SND_OP_RDC0   8'h03
`define SND_OP_RDC1   8'h0b
`define SND_OP_RDC2   8'h3b
`define SND_OP_RDC4   8'h6b
`define SND_OP_LD1    8'h02
`define SND_OP_LD4    8'h32
`define SND_OP_RLD1   8'h84
`define SND_OP_RLD4   8'h34
`define SND_OP_EXEC   8'h10
`define SND_OP_ERASE  8'hd8
`define SND_OP_ID     8'h9f
`define SND_OP_RST    8'hff
`define SND_ROW_BITS  5'd24
`define SND_COL_BITS  5'd16
`define SND_BYTE_BITS 5'd8
`define SND_PAGE      12'd2112
`define SND_ST_BUSY   0
`define SND_ST_WEL    1
// Identity values are arbitrary
`define SND_MAKER_ID  8'h5a
`define SND_DEV_ID    8'ha5
`define SND_CONT_ID   8'h3c
`define SND_CLK_NS    8
`define SND_T_RD_NS   20000
`define SND_T_PROG_NS 40000
`define SND_T_BERS_NS 80000
`define SND_T_RST_NS  10000
`define SND_T_PWR_NS  250000
`define SND_CYC(t)    (((t) + `SND_CLK_NS - 1) / `SND_CLK_NS)
`endif

// ### snd_pkg.sv
`include "snd_map.svh"
package snd_pkg;
  typedef enum {SND_OPC, SND_ADDR, SND_DIN, SND_DOUT, SND_SKIP} snd_state_t;

  function automatic logic snd_ok(input logic [7:0] op, input logic bsy, input logic write_enable_latch, input logic por);
    if (por)
      return 1'b0;
    if (bsy)
      return (op == `SND_OP_GETF) || (op == `SND_OP_RST);
    case (op)
      `SND_OP_EXEC, `SND_OP_ERASE, `SND_OP_LD1, `SND_OP_LD4, `SND_OP_RLD1, `SND_OP_RLD4: return write_enable_latch;
      default: return 1'b1;
    endcase
  endfunction : snd_ok

  function automatic logic [4:0] snd_need(input logic [7:0] op);
    case (op)
      `SND_OP_PGRD, `SND_OP_EXEC, `SND_OP_ERASE: return `SND_ROW_BITS;
      `SND_OP_RDC0, `SND_OP_RDC1, `SND_OP_RDC2, `SND_OP_RDC4,
      `SND_OP_LD1, `SND_OP_LD4, `SND_OP_RLD1, `SND_OP_RLD4: return `SND_COL_BITS;
      `SND_OP_GETF, `SND_OP_ID: return `SND_BYTE_BITS;
      default: return 5'd0;
    endcase
  endfunction : snd_need

  function automatic logic [3:0] snd_lanes(input logic [7:0] op);
    case (op)
      `SND_OP_RDC2: return 4'd2;
      `SND_OP_RDC4, `SND_OP_LD4, `SND_OP_RLD4: return 4'd4;
      default: return 4'd1;
    endcase
  endfunction : snd_lanes
endpackage : snd_pkg

// ### snd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module snd_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : snd_sync
`default_nettype wire

// ### snd_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "snd_map.svh"
module snd_sequencer import snd_pkg::*; #(
  parameter int unsigned RD_CYC   = `SND_CYC(`SND_T_RD_NS),
  parameter int unsigned PROG_CYC = `SND_CYC(`SND_T_PROG_NS),
  parameter int unsigned BERS_CYC = `SND_CYC(`SND_T_BERS_NS),
  parameter int unsigned RST_CYC  = `SND_CYC(`SND_T_RST_NS),
  parameter int unsigned PWR_CYC  = `SND_CYC(`SND_T_PWR_NS)
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        sck,
  input  wire logic        cs_b,
  input  wire logic        hold_b,
  input  wire logic        supply_ok,
  input  wire logic [3:0]  io_in,
  output var  logic [3:0]  io_out_r,
  output var  logic [3:0]  io_oe_r,
  output var  logic        wp_r,
  output var  logic        busy_r,
  output var  logic        array_read_r,
  output var  logic        array_prog_r,
  output var  logic        array_erase_r,
  output var  logic [15:0] array_row_r
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  logic       sck_s, cs_s, hold_s, supply_s, sck_d_r, hold_r;
  logic [3:0] io_s;

  snd_sync #(.W(8), .INIT(8'h60)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({supply_ok, hold_b, cs_b, sck, io_in}),
    .q     ({supply_s, hold_s, cs_s, sck_s, io_s})
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      sck_d_r <= 1'b0;
    else
      sck_d_r <= sck_s;
  end

  // Edges are seen only while selected and not paused
  logic sck_rise, sck_fall;
  assign sck_rise = sck_s & ~sck_d_r & ~cs_s & ~hold_r;
  assign sck_fall = ~sck_s & sck_d_r & ~cs_s & ~hold_r;

  // Pause may only toggle while the clock is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      hold_r <= 1'b0;
    else if (!sck_s)
      hold_r <= ~hold_s;
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  snd_state_t  state_r;
  logic [7:0]  opc_r, byte_r, fetch_byte;
  logic [23:0] sh_r;
  logic [4:0]  cnt_r, need_r;
  logic [3:0]  lanes_r, bits_r, obits_r;
  logic [11:0] col_r;
  logic [19:0] busy_cnt_r, por_cnt_r;
  logic        wel_r, por_r;
  logic [7:0]  cache_mem [0:2111];

  logic [7:0]  op_full, din_byte;
  logic [23:0] addr_full;
  logic        opc_last, ok_now, ev_cmd, addr_last, is_arr, is_load, byte_done, din_wr;
  logic        ev_op, ev_auto, ev_rst, out_fetch, past_end;

  assign op_full   = {opc_r[6:0], io_s[0]};
  assign addr_full = {sh_r[22:0], io_s[0]};
  assign opc_last  = sck_rise && (state_r == SND_OPC) && (cnt_r == 5'd7);
  assign ok_now    = snd_ok(op_full, busy_r, wel_r, por_r);
  assign ev_cmd    = opc_last && ok_now;
  assign addr_last = sck_rise && (state_r == SND_ADDR) && (cnt_r == need_r - 5'd1);
  assign is_arr    = (opc_r == `SND_OP_PGRD) || (opc_r == `SND_OP_EXEC) || (opc_r == `SND_OP_ERASE);
  assign is_load   = (opc_r == `SND_OP_LD1) || (opc_r == `SND_OP_LD4) ||
                     (opc_r == `SND_OP_RLD1) || (opc_r == `SND_OP_RLD4);
  assign ev_op     = addr_last && is_arr;
  assign ev_auto   = por_r && supply_s && (por_cnt_r == 20'(PWR_CYC - 1));
  assign ev_rst    = (ev_cmd && (op_full == `SND_OP_RST)) || ev_auto;
  assign din_byte  = (lanes_r == 4'd4) ? {byte_r[3:0], io_s} : {byte_r[6:0], io_s[0]};
  assign byte_done = (bits_r + lanes_r) == 4'd8;
  assign din_wr    = sck_rise && (state_r == SND_DIN) && byte_done && (col_r < `SND_PAGE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SND_OPC;
      opc_r   <= 8'h00;
      sh_r    <= 24'h000000;
      cnt_r   <= 5'h00;
      need_r  <= 5'h00;
      lanes_r <= 4'h1;
      bits_r  <= 4'h0;
      byte_r  <= 8'h00;
      col_r   <= 12'h000;
    end else if (cs_s) begin
      state_r <= SND_OPC;
      cnt_r   <= 5'h00;
    end else if (sck_rise) begin
      case (state_r)
        SND_OPC: begin
          opc_r <= op_full;
          cnt_r <= cnt_r + 5'd1;
          if (cnt_r == 5'd7) begin
            cnt_r   <= 5'h00;
            need_r  <= snd_need(op_full);
            lanes_r <= snd_lanes(op_full);
            state_r <= (ok_now && snd_need(op_full) != 5'd0) ? SND_ADDR : SND_SKIP;
          end
        end
        SND_ADDR: begin
          sh_r  <= addr_full;
          cnt_r <= cnt_r + 5'd1;
          if (addr_last) begin
            bits_r <= 4'h0;
            col_r  <= (need_r == `SND_COL_BITS) ? addr_full[11:0] : 12'h000;
            if (is_arr)
              state_r <= SND_SKIP;
            else if (is_load)
              state_r <= SND_DIN;
            else
              state_r <= SND_DOUT;
          end
        end
        SND_DIN: begin
          byte_r <= din_byte;
          bits_r <= byte_done ? 4'h0 : bits_r + lanes_r;
          if (din_wr)
            col_r <= col_r + 12'd1;
        end
        default: ;
      endcase
    end else if (out_fetch && col_r < `SND_PAGE) begin
      col_r <= col_r + 12'd1;
    end
  end

  // Only supplied bytes change; the rest of the cache keeps its data
  always_ff @(posedge clk) begin
    if (din_wr)
      cache_mem[col_r] <= din_byte;
  end

  // ----------------------------------------------------------------
  // Write latch, busy timer, power-up
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      wel_r <= 1'b0;
    else if (ev_cmd && op_full == `SND_OP_WREN)
      wel_r <= 1'b1;
    else if ((ev_cmd && op_full == `SND_OP_WRDI) || ev_rst || (ev_op && opc_r != `SND_OP_PGRD))
      wel_r <= 1'b0;
  end

  // Pause does not touch the timer, so array work runs on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_r <= 20'h00000;
      busy_r     <= 1'b0;
    end else if (ev_rst) begin
      busy_cnt_r <= 20'(RST_CYC);
      busy_r     <= 1'b1;
    end else if (ev_op) begin
      if (opc_r == `SND_OP_PGRD)
        busy_cnt_r <= 20'(RD_CYC);
      else if (opc_r == `SND_OP_EXEC)
        busy_cnt_r <= 20'(PROG_CYC);
      else
        busy_cnt_r <= 20'(BERS_CYC);
      busy_r <= 1'b1;
    end else if (busy_cnt_r != 20'h00000) begin
      busy_cnt_r <= busy_cnt_r - 20'd1;
      busy_r     <= busy_cnt_r > 20'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      array_read_r  <= 1'b0;
      array_prog_r  <= 1'b0;
      array_erase_r <= 1'b0;
      array_row_r   <= 16'h0000;
    end else begin
      array_read_r  <= ev_op && opc_r == `SND_OP_PGRD;
      array_prog_r  <= ev_op && opc_r == `SND_OP_EXEC;
      array_erase_r <= ev_op && opc_r == `SND_OP_ERASE;
      if (ev_op)
        array_row_r <= addr_full[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_r     <= 1'b1;
      por_cnt_r <= 20'h00000;
      wp_r      <= 1'b0;
    end else if (ev_auto) begin
      por_r <= 1'b0;
      wp_r  <= 1'b1;
    end else if (por_r && supply_s) begin
      por_cnt_r <= por_cnt_r + 20'd1;
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  always_comb begin
    case (opc_r)
      `SND_OP_GETF: begin
        fetch_byte              = 8'h00;
        fetch_byte[`SND_ST_BUSY] = busy_r;
        fetch_byte[`SND_ST_WEL]  = wel_r;
      end
      `SND_OP_ID:
        case (col_r)
          12'd0:                fetch_byte = `SND_MAKER_ID;
          12'd1:                fetch_byte = `SND_DEV_ID;
          12'd2, 12'd3, 12'd4:  fetch_byte = `SND_CONT_ID;
          default:              fetch_byte = 8'h00;
        endcase
      default:
        fetch_byte = (col_r < `SND_PAGE) ? cache_mem[col_r] : 8'h00;
    endcase
  end

  logic [7:0] ob;
  logic [7:0] byte_out_r;
  assign out_fetch = sck_fall && (state_r == SND_DOUT) && (obits_r == 4'h0);
  assign past_end  = (opc_r != `SND_OP_GETF) && (opc_r != `SND_OP_ID) && (col_r >= `SND_PAGE);
  assign ob        = (obits_r == 4'h0) ? fetch_byte : byte_out_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_out_r   <= 4'h0;
      io_oe_r    <= 4'h0;
      obits_r    <= 4'h0;
      byte_out_r <= 8'h00;
    end else if (cs_s || hold_r || state_r != SND_DOUT) begin
      io_oe_r <= 4'h0;
      if (state_r != SND_DOUT)
        obits_r <= 4'h0;
    end else if (sck_fall) begin
      if (obits_r == 4'h0 && past_end) begin
        io_oe_r <= 4'h0;
      end else begin
        byte_out_r <= ob << lanes_r;
        obits_r    <= ((obits_r == 4'h0) ? 4'd8 : obits_r) - lanes_r;
        case (lanes_r)
          4'd4: begin
            io_out_r <= ob[7:4];
            io_oe_r  <= 4'hf;
          end
          4'd2: begin
            io_out_r <= {2'b00, ob[7:6]};
            io_oe_r  <= 4'h3;
          end
          default: begin
            io_out_r <= {2'b00, ob[7], 1'b0};
            io_oe_r  <= 4'h2;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence seq_low_pause;
    !hold_s && !sck_s;
  endsequence
  sequence seq_busy_start;
    busy_r && busy_cnt_r != 20'h00000;
  endsequence

  chk_rdc_lanes: assert property (ev_cmd && op_full == `SND_OP_RDC4 |=> lanes_r == 4'd4)
    else $error("quad read not decoded");
  chk_wel_gate: assert property (opc_last && op_full == `SND_OP_EXEC && !wel_r && !busy_r
    |=> state_r == SND_SKIP)
    else $error("execute taken without write enable");
  chk_wel_set: assert property (ev_cmd && op_full == `SND_OP_WREN |=> wel_r [*2])
    else $error("write enable latch not set");
  chk_read_busy: assert property (ev_op && opc_r == `SND_OP_PGRD |=> seq_busy_start and array_read_r)
    else $error("page read not busy");
  chk_prog_busy: assert property (ev_op && opc_r == `SND_OP_EXEC |=> seq_busy_start and array_prog_r)
    else $error("program not busy");
  chk_erase_busy: assert property (ev_op && opc_r == `SND_OP_ERASE |=> seq_busy_start and !wel_r)
    else $error("erase not busy");
  chk_col_load: assert property (addr_last && is_load |=> col_r == $past(addr_full[11:0]) && state_r == SND_DIN)
    else $error("load column not taken");
  // Column steps once per byte and stops at the page end
  chk_page_drop: assert property (sck_rise && state_r == SND_DIN && byte_done
    |=> col_r == (($past(col_r) < `SND_PAGE) ? $past(col_r) + 12'd1 : $past(col_r)))
    else $error("write past page end");
  chk_end_hiz: assert property (out_fetch && past_end |=> io_oe_r == 4'h0)
    else $error("output driven past cache end");
  chk_hold_enter: assert property (seq_low_pause |=> hold_r ##1 io_oe_r == 4'h0)
    else $error("pause not entered");
  chk_pause_keep: assert property (hold_r && busy_cnt_r > 20'd1 |=> busy_r)
    else $error("pause aborted array work");
  chk_wp_reset: assert property ($rose(wp_r) |-> busy_r && !por_r)
    else $error("power-up reset missing");
  chk_cs_idle: assert property (cs_s |=> io_oe_r == 4'h0 && state_r == SND_OPC)
    else $error("deselected device active");
endmodule : snd_sequencer
`default_nettype wire

// ### snd_host.sv
`timescale 1ns/1ps
`default_nettype none
module snd_host (
  input  wire logic [3:0] io_out_r,
  input  wire logic [3:0] io_oe_r,
  output var  logic       sck,
  output var  logic       cs_b,
  output var  logic [3:0] io_in
);
  initial begin
    sck   = 1'b0;
    cs_b  = 1'b1;
    io_in = 4'h0;
  end

  // 62.5 ns halves: 125 ns link, mode 0, free running against clk
  task automatic half();
    #62.5;
  endtask : half

  task automatic beat(input logic [3:0] d, output logic [3:0] q, output logic [3:0] oe);
    io_in = d;
    half();
    sck = 1'b1;
    // Undriven lines read as the inverse of stale data
    q   = ~(io_out_r ^ io_oe_r);
    oe  = io_oe_r;
    half();
    sck = 1'b0;
  endtask : beat

  task automatic send(input logic [7:0] b, input int ln);
    logic [3:0] q;
    logic [3:0] oe;
    for (int i = 8 - ln; i >= 0; i -= ln) begin
      // Unused lines toggle so they never sit at a steady level
      beat((ln == 4) ? b[i +: 4] : {~io_in[3:1], b[i]}, q, oe);
    end
  endtask : send

  task automatic recv(input int ln, output logic [7:0] b, output logic [3:0] seen);
    logic [3:0] q;
    logic [3:0] oe;
    b    = 8'h00;
    seen = 4'h0;
    for (int i = 0; i < 8 / ln; i++) begin
      beat(~io_in, q, oe);
      seen = seen | oe;
      b    = (b << ln) | ((ln == 1) ? {7'h00, q[1]} : (ln == 2) ? {6'h00, q[1:0]} : {4'h0, q});
    end
  endtask : recv

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nab);
    half();
    cs_b = 1'b0;
    send(op, 1);
    for (int k = nab - 1; k >= 0; k--) begin
      send(a[8 * k +: 8], 1);
    end
  endtask : cmd

  task automatic stop();
    half();
    cs_b  = 1'b1;
    // Released lines flip so stale bits cannot pass as data
    io_in = ~io_in;
    half();
  endtask : stop
endmodule : snd_host
`default_nettype wire

// ### spi_nand_command_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "snd_map.svh"
module spi_nand_command_sequencer_bench;
  localparam int RD_N = 600;
  localparam int PG_N = 800;
  localparam int ER_N = 700;
  localparam int RS_N = 20;
  localparam int PW_N = 30;
  logic        clk, rst_b, hold_b, supply_ok, sck, cs_b, wp_r, busy_r, rd_p, pg_p, er_p;
  logic [3:0]  io_in, io_out_r, io_oe_r;
  logic [15:0] array_row_r;
  int          err_count = 0;
  int          checks = 0;
  int          run = 0;
  int          last_run = 0;
  int          pulses[3] = '{0, 0, 0};

  snd_sequencer #(.RD_CYC(RD_N), .PROG_CYC(PG_N), .BERS_CYC(ER_N), .RST_CYC(RS_N), .PWR_CYC(PW_N)) uut (
    .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .hold_b(hold_b), .supply_ok(supply_ok), .io_in(io_in),
    .io_out_r(io_out_r), .io_oe_r(io_oe_r), .wp_r(wp_r), .busy_r(busy_r), .array_read_r(rd_p),
    .array_prog_r(pg_p), .array_erase_r(er_p), .array_row_r(array_row_r));
  snd_host host (.io_out_r(io_out_r), .io_oe_r(io_oe_r), .sck(sck), .cs_b(cs_b), .io_in(io_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Start pulses, and the length of the last busy stretch
  always @(negedge clk) begin
    if (rd_p === 1'b1) pulses[0]++;
    if (pg_p === 1'b1) pulses[1]++;
    if (er_p === 1'b1) pulses[2]++;
    if (busy_r === 1'b1) begin
      run++;
    end else if (run != 0) begin
      last_run = run;
      run      = 0;
    end
  end

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : cmp

  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic simple(input logic [7:0] op);
    host.cmd(op, 24'h0, 0);
    host.stop();
  endtask : simple

  task automatic status(input logic [15:0] exp);
    logic [7:0] s;
    logic [3:0] oe;
    host.cmd(`SND_OP_GETF, 24'hc0, 1);
    host.recv(1, s, oe);
    host.stop();
    cmp("status", exp, {8'h00, s});
  endtask : status

  // Length is judged from the monitor, not by sampling busy now and then
  task automatic wait_idle(input int n);
    int t = 0;
    while (busy_r !== 1'b0 && t < 5000) begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    cmp("busy length", 16'h1, 16'(t < 5000 && last_run >= n - 1 && last_run <= n + 1));
  endtask : wait_idle

  task automatic load(input logic [7:0] op, input logic [11:0] col, input logic [31:0] d, input int n, input int ln);
    host.cmd(op, {12'h000, col}, 2);
    for (int i = 0; i < n; i++) begin
      host.send(d[31 - 8 * i -: 8], ln);
    end
    host.stop();
  endtask : load

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power();
    int t = 0;
    supply_ok = 1'b1;
    while (wp_r !== 1'b1 && t < 200) begin
      @(negedge clk);
      t++;
    end
    cmp("power-up delay", 16'h1, 16'(t >= PW_N && t <= PW_N + 4));
    @(negedge clk);
    cmp("reset busy", 16'h1, {15'h0, busy_r});
    wait_idle(RS_N);
    repeat (4 * PW_N) @(negedge clk);
  endtask : t_power

  task automatic t_id(input logic pause);
    logic [7:0] b;
    logic [3:0] q, oe, seen;
    logic [7:0] ids[5] = '{`SND_MAKER_ID, `SND_DEV_ID, `SND_CONT_ID, `SND_CONT_ID, `SND_CONT_ID};
    seen = 4'h0;
    host.cmd(`SND_OP_ID, 24'h0, 0);
    @(negedge clk);
    hold_b = !pause;
    for (int i = 0; i < 8 * pause; i++) begin
      host.beat(4'hf, q, oe);
      seen = seen | oe;
    end
    @(negedge clk);
    hold_b = 1'b1;
    cmp("paused drive", 16'h0, {12'h0, seen});
    host.send(8'h00, 1);
    for (int i = 0; i < 5; i++) begin
      host.recv(1, b, oe);
      cmp("id byte", {8'h00, ids[i]}, {8'h00, b});
    end
    host.stop();
  endtask : t_id

  task automatic t_wel();
    host.send(`SND_OP_WREN, 1);
    status(16'h0);
    simple(`SND_OP_WREN);
    status(16'h2);
    simple(`SND_OP_WRDI);
    status(16'h0);
  endtask : t_wel

  task automatic t_cache();
    logic [7:0] b;
    logic [3:0] oe;
    logic [7:0] ops[4] = '{`SND_OP_RDC0, `SND_OP_RDC1, `SND_OP_RDC2, `SND_OP_RDC4};
    int         ln[4] = '{1, 1, 2, 4};
    logic [7:0] want[4] = '{8'h11, 8'h99, 8'h33, 8'h66};
    simple(`SND_OP_WREN);
    load(`SND_OP_LD1, 12'h000, 32'h11225566, 4, 1);
    load(`SND_OP_RLD4, 12'h001, 32'h99000000, 1, 4);
    load(`SND_OP_RLD1, 12'h002, 32'h33000000, 1, 1);
    load(`SND_OP_LD4, 12'h83e, 32'ha1b2c300, 3, 4);
    simple(`SND_OP_WRDI);
    load(`SND_OP_LD1, 12'h003, 32'hee000000, 1, 1);
    host.cmd(`SND_OP_EXEC, 24'h000777, 3);
    host.stop();
    cmp("refused start", 16'h0, 16'(pulses[1]) | {15'h0, busy_r});
    for (int k = 0; k < 4; k++) begin
      host.cmd(ops[k], 24'h0, 2);
      for (int i = 0; i < 4; i++) begin
        host.recv(ln[k], b, oe);
        cmp("cache byte", {8'h00, want[i]}, {8'h00, b});
      end
      host.stop();
    end
    host.cmd(`SND_OP_RDC0, 24'h00083e, 2);
    host.recv(1, b, oe);
    cmp("next to last", 16'h00a1, {8'h00, b});
    host.recv(1, b, oe);
    cmp("last byte", 16'h00b2, {8'h00, b});
    host.recv(1, b, oe);
    cmp("past end", 16'h0, {12'h0, oe});
    host.stop();
  endtask : t_cache

  task automatic t_array(input logic [7:0] op, input logic [15:0] row, input int n, input int k);
    int c0 = pulses[k];
    if (op != `SND_OP_PGRD) begin
      simple(`SND_OP_WREN);
    end
    host.cmd(op, {8'h00, row}, 3);
    host.stop();
    cmp("array start", 16'(c0 + 1), 16'(pulses[k]));
    cmp("array row", row, array_row_r);
    hold_b = 1'b0;
    repeat (40) @(negedge clk);
    hold_b = 1'b1;
    status(16'h1);
    wait_idle(n);
    status(16'h0);
  endtask : t_array

  initial begin
    rst_b     = 1'b0;
    hold_b    = 1'b1;
    supply_ok = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_power();
    t_id(1'b0);
    t_wel();
    t_cache();
    t_array(`SND_OP_PGRD, 16'h0041, RD_N, 0);
    t_array(`SND_OP_EXEC, 16'h0040, PG_N, 1);
    t_array(`SND_OP_ERASE, 16'h0080, ER_N, 2);
    t_id(1'b1);
    give_verdict();
  end

  // About four times the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule : spi_nand_command_sequencer_bench
`default_nettype wire
